// File: timer_defs.svh
// Register indices, field positions, reset values and counts of the dual timer
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
`define IDX_TIMER_CONTROL   8'h88
`define IDX_TIMER_MODE      8'h89
`define IDX_TIMER0_LOW      8'h8A
`define IDX_TIMER1_LOW      8'h8B
`define IDX_TIMER0_HIGH     8'h8C
`define IDX_TIMER1_HIGH     8'h8D
`define IDX_EXT_IRQ_CONFIG  8'h8E
`define IDX_PRESCALE_CTRL   8'h8F
`define TC_TIMER1_OVF       7
`define TC_TIMER1_RUN       6
`define TC_TIMER0_OVF       5
`define TC_TIMER0_RUN       4
`define TC_EXT1_FLAG        3
`define TC_EXT1_TYPE        2
`define TC_EXT0_FLAG        1
`define TC_EXT0_TYPE        0
`define RESET_BYTE          8'h00
`define MODE_13BIT          2'h0
`define MODE_16BIT          2'h1
`define MODE_RELOAD         2'h2
`define MODE_SPLIT          2'h3
`define PRESCALE_DIV        12
`endif

// File: timer_pkg.sv
// Types shared by the dual timer modules
package timer_pkg;
  typedef logic [1:0] mode_t;
  // One nibble of the timer mode register
  typedef struct packed {
    logic  gate;
    logic  csel;
    mode_t mode;
  } timer_cfg_s;
endpackage : timer_pkg

// File: tick_divider.sv
// Divider giving a one-cycle prescaled tick from the system clock
`timescale 1ns/100ps
`default_nettype none
module tick_divider
#(
  parameter int DIV = 12
)
(
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);
  import timer_pkg::*;
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_reg;

  // Free running count; tick registered from the last count of each period, high one cycle later
  always_ff @(posedge clk)
  begin
    if (reset || cnt_reg == LAST)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      tick <= 1'b0;
    else
      tick <= (cnt_reg == LAST);
  end

  a_tick_single: assert property (@(posedge clk) disable iff (reset)
    (DIV > 1 && tick) |=> !tick) else $error("prescaled tick longer than one cycle");
endmodule : tick_divider
`default_nettype wire

// File: timer_count_unit.sv
// Count step of one timer in each of its four modes
`timescale 1ns/100ps
`default_nettype none
`include "timer_defs.svh"
module timer_count_unit
(
  input  wire timer_pkg::mode_t mode,
  input  wire logic [7:0]       low,
  input  wire logic [7:0]       high,
  input  wire logic             inc_lo,
  input  wire logic             inc_hi,
  output logic [7:0]            low_next,
  output logic [7:0]            high_next,
  output logic                  ovf_lo,
  output logic                  ovf_hi
);
  import timer_pkg::*;
  logic [12:0] c13;
  logic [15:0] c16;

  // Next count and overflow for the selected mode
  always_comb
  begin
    low_next  = low;
    high_next = high;
    ovf_lo    = 1'b0;
    ovf_hi    = 1'b0;
    c13       = {high, low[4:0]} + 13'h0001;
    c16       = {high, low} + 16'h0001;
    case (mode)
      `MODE_13BIT:
      begin
        // Upper three low bits are left alone, software masks them
        if (inc_lo)
        begin
          low_next  = {low[7:5], c13[4:0]};
          high_next = c13[12:5];
          ovf_lo    = (c13 == 13'h0000);
        end
      end
      `MODE_16BIT:
      begin
        if (inc_lo)
        begin
          {high_next, low_next} = c16;
          ovf_lo = (c16 == 16'h0000);
        end
      end
      `MODE_RELOAD:
      begin
        // High byte is the reload value and is never changed
        if (inc_lo)
        begin
          ovf_lo   = (low == 8'hFF);
          low_next = (low == 8'hFF) ? high : low + 8'h01;
        end
      end
      default:
      begin
        // Two independent byte counters
        if (inc_lo)
        begin
          low_next = low + 8'h01;
          ovf_lo   = (low == 8'hFF);
        end
        if (inc_hi)
        begin
          high_next = high + 8'h01;
          ovf_hi    = (high == 8'hFF);
        end
      end
    endcase
  end
endmodule : timer_count_unit
`default_nettype wire

// File: dual_timer_control.sv
// Dual counter/timer with control, mode and count registers on Wishbone
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "timer_defs.svh"
module dual_timer_control
#(
  parameter int PRESCALE = `PRESCALE_DIV
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [9:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        ext_irq0_input,
  input  wire logic        ext_irq1_input,
  input  wire logic        timer0_count_pin,
  input  wire logic        timer1_count_pin,
  input  wire logic        timer0_vector,
  input  wire logic        timer1_vector,
  input  wire logic        ext_irq0_vector,
  input  wire logic        ext_irq1_vector,
  output logic             timer0_overflow_flag,
  output logic             timer1_overflow_flag,
  output logic             ext_irq0_flag,
  output logic             ext_irq1_flag
);
  import timer_pkg::*;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] target);
    hit = (idx == target);
  endfunction : hit

  logic [7:0]  timer_control_reg;
  logic [7:0]  timer_control_next;
  logic [7:0]  timer_mode_reg;
  logic [7:0]  ext_irq_config_reg;
  logic [7:0]  prescale_reg;
  logic [7:0]  low_reg [2];
  logic [7:0]  high_reg [2];
  logic [7:0]  low_step [2];
  logic [7:0]  high_step [2];
  logic [1:0]  inc_lo;
  logic [1:0]  inc_hi;
  logic [1:0]  ovf_lo;
  logic [1:0]  ovf_hi;
  logic [1:0]  act;
  logic [1:0]  act_d_reg;
  logic [1:0]  pin_d_reg;
  logic [1:0]  fall;
  logic [1:0]  run;
  logic [1:0]  tick;
  logic [1:0]  ext_set;
  logic [7:0]  idx;
  logic [7:0]  bit_mask;
  logic        wr;
  logic        presc_tick;
  logic        split0;
  logic        set_tf0;
  logic        set_tf1;
  timer_cfg_s  cfg [2];

  assign idx      = adr_i[9:2];
  assign wr       = cyc_i & stb_i & we_i & sel_i[0] & ~ack_o;
  assign cfg[0]   = timer_cfg_s'(timer_mode_reg[3:0]);
  assign cfg[1]   = timer_cfg_s'(timer_mode_reg[7:4]);
  assign split0   = (cfg[0].mode == `MODE_SPLIT);
  // Lane 1 acts as a per-bit write mask on control register writes, so single bits change alone
  assign bit_mask = sel_i[1] ? dat_i[15:8] : 8'hFF;

  assign timer1_overflow_flag = timer_control_reg[`TC_TIMER1_OVF];
  assign timer0_overflow_flag = timer_control_reg[`TC_TIMER0_OVF];
  assign ext_irq1_flag        = timer_control_reg[`TC_EXT1_FLAG];
  assign ext_irq0_flag        = timer_control_reg[`TC_EXT0_FLAG];

  tick_divider #(
    .DIV   (PRESCALE)
  ) u_prescale (
    .clk   (clk),
    .reset (reset),
    .tick  (presc_tick)
  );

  // Input activity against polarity, previous samples for edges
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      act_d_reg <= 2'h0;
      pin_d_reg <= 2'h3;
    end
    else
    begin
      act_d_reg <= act;
      pin_d_reg <= {timer1_count_pin, timer0_count_pin};
    end
  end

  // Per-timer run, tick source and interrupt event decode
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_timer
      logic pin_now;
      logic ext_in;
      logic base_tick;
      assign pin_now   = i ? timer1_count_pin : timer0_count_pin;
      assign ext_in    = i ? ext_irq1_input : ext_irq0_input;
      // Polarity bit set means active high
      assign act[i]    = ~(ext_in ^ ext_irq_config_reg[i]);
      assign fall[i]   = pin_d_reg[i] & ~pin_now;
      assign base_tick = prescale_reg[i] ? presc_tick : 1'b1;
      // Type bit: zero is level, one is edge
      assign ext_set[i] = timer_control_reg[i ? `TC_EXT1_TYPE : `TC_EXT0_TYPE]
                          ? (act[i] & ~act_d_reg[i]) : act[i];

      timer_count_unit u_count (
        .mode      (cfg[i].mode),
        .low       (low_reg[i]),
        .high      (high_reg[i]),
        .inc_lo    (inc_lo[i]),
        .inc_hi    (inc_hi[i]),
        .low_next  (low_step[i]),
        .high_next (high_step[i]),
        .ovf_lo    (ovf_lo[i]),
        .ovf_hi    (ovf_hi[i])
      );

      if (i == 0)
      begin : g_t0
        assign run[0]  = timer_control_reg[`TC_TIMER0_RUN]
                         & (~cfg[0].gate | act[0]);
        assign tick[0] = cfg[0].csel ? fall[0] : base_tick;
        assign inc_lo[0] = run[0] & tick[0];
        // Split high byte: clock only, run by timer 1 bit
        assign inc_hi[0] = split0 & timer_control_reg[`TC_TIMER1_RUN]
                           & base_tick;
      end
      else
      begin : g_t1
        // With timer 0 split, timer 1 runs by its mode alone, no pin clock
        assign run[1]  = split0 ? 1'b1 : (timer_control_reg[`TC_TIMER1_RUN]
                         & (~cfg[1].gate | act[1]));
        assign tick[1] = (cfg[1].csel & ~split0) ? fall[1] : base_tick;
        assign inc_lo[1] = run[1] & tick[1]
                           & (cfg[1].mode != `MODE_SPLIT);
        assign inc_hi[1] = 1'b0;
      end
    end
  endgenerate

  assign set_tf0 = ovf_lo[0];
  // Timer 1 loses its flag to the split timer 0 high byte
  assign set_tf1 = split0 ? ovf_hi[0] : ovf_lo[1];

  // Control register: vector clears, software write, then hardware sets win
  always_comb
  begin
    timer_control_next = timer_control_reg;
    if (timer1_vector)
      timer_control_next[`TC_TIMER1_OVF] = 1'b0;
    if (timer0_vector)
      timer_control_next[`TC_TIMER0_OVF] = 1'b0;
    if (ext_irq1_vector && timer_control_reg[`TC_EXT1_TYPE])
      timer_control_next[`TC_EXT1_FLAG] = 1'b0;
    if (ext_irq0_vector && timer_control_reg[`TC_EXT0_TYPE])
      timer_control_next[`TC_EXT0_FLAG] = 1'b0;
    if (wr && hit(idx, `IDX_TIMER_CONTROL))
      timer_control_next = (timer_control_next & ~bit_mask)
                           | (dat_i[7:0] & bit_mask);
    if (set_tf1)
      timer_control_next[`TC_TIMER1_OVF] = 1'b1;
    if (set_tf0)
      timer_control_next[`TC_TIMER0_OVF] = 1'b1;
    if (ext_set[1])
      timer_control_next[`TC_EXT1_FLAG] = 1'b1;
    if (ext_set[0])
      timer_control_next[`TC_EXT0_FLAG] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      timer_control_reg <= `RESET_BYTE;
    else
      timer_control_reg <= timer_control_next;
  end

  // Configuration registers: mode written whole, input config and prescale keep bits 1:0 only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      timer_mode_reg     <= `RESET_BYTE;
      ext_irq_config_reg <= `RESET_BYTE;
      prescale_reg       <= `RESET_BYTE;
    end
    else if (wr)
    begin
      if (hit(idx, `IDX_TIMER_MODE))
        timer_mode_reg <= dat_i[7:0];
      if (hit(idx, `IDX_EXT_IRQ_CONFIG))
        ext_irq_config_reg <= {6'h00, dat_i[1:0]};
      if (hit(idx, `IDX_PRESCALE_CTRL))
        prescale_reg <= {6'h00, dat_i[1:0]};
    end
  end

  // Count bytes: a software write beats the count step in that cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      low_reg[0]  <= `RESET_BYTE;
      high_reg[0] <= `RESET_BYTE;
      low_reg[1]  <= `RESET_BYTE;
      high_reg[1] <= `RESET_BYTE;
    end
    else
    begin
      // Run bits never touch the counts, they only gate the step
      low_reg[0]  <= (wr && hit(idx, `IDX_TIMER0_LOW)) ? dat_i[7:0] : low_step[0];
      high_reg[0] <= (wr && hit(idx, `IDX_TIMER0_HIGH)) ? dat_i[7:0] : high_step[0];
      low_reg[1]  <= (wr && hit(idx, `IDX_TIMER1_LOW)) ? dat_i[7:0] : low_step[1];
      high_reg[1] <= (wr && hit(idx, `IDX_TIMER1_HIGH)) ? dat_i[7:0] : high_step[1];
    end
  end

  // Wishbone answer: one wait state, ack for one cycle, unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      case (idx)
        `IDX_TIMER_CONTROL:  dat_o <= {24'h000000, timer_control_reg};
        `IDX_TIMER_MODE:     dat_o <= {24'h000000, timer_mode_reg};
        `IDX_TIMER0_LOW:     dat_o <= {24'h000000, low_reg[0]};
        `IDX_TIMER1_LOW:     dat_o <= {24'h000000, low_reg[1]};
        `IDX_TIMER0_HIGH:    dat_o <= {24'h000000, high_reg[0]};
        `IDX_TIMER1_HIGH:    dat_o <= {24'h000000, high_reg[1]};
        `IDX_EXT_IRQ_CONFIG: dat_o <= {24'h000000, ext_irq_config_reg};
        `IDX_PRESCALE_CTRL:  dat_o <= {24'h000000, prescale_reg};
        default:             dat_o <= 32'h0000_0000;
      endcase
    end
  end

  a_tf0_overflow_set: assert property (@(posedge clk) disable iff (reset)
    set_tf0 |=> timer0_overflow_flag) else $error("timer 0 overflow lost");
  a_tf1_overflow_set: assert property (@(posedge clk) disable iff (reset)
    set_tf1 |=> timer1_overflow_flag) else $error("timer 1 overflow lost");
  a_tf0_vector_clear: assert property (@(posedge clk) disable iff (reset)
    (timer0_vector && !set_tf0 && !(wr && hit(idx, `IDX_TIMER_CONTROL)))
    |=> !timer0_overflow_flag) else $error("vector did not clear timer 0 flag");
  a_t0_stopped_hold: assert property (@(posedge clk) disable iff (reset)
    (!timer_control_reg[`TC_TIMER0_RUN] && !(wr && hit(idx, `IDX_TIMER0_LOW)))
    |=> low_reg[0] == $past(low_reg[0])) else $error("stopped timer 0 moved");
  a_t0_gate_hold: assert property (@(posedge clk) disable iff (reset)
    (cfg[0].gate && !act[0] && !(wr && hit(idx, `IDX_TIMER0_LOW)))
    |=> low_reg[0] == $past(low_reg[0])) else $error("gated timer 0 moved");
  a_t1_run_count: assert property (@(posedge clk) disable iff (reset)
    (!split0 && timer_control_reg[`TC_TIMER1_RUN] && !cfg[1].gate && !cfg[1].csel
     && prescale_reg[1] == 1'b0 && cfg[1].mode == `MODE_16BIT && !wr)
    |=> low_reg[1] == $past(low_reg[1]) + 8'h01) else $error("timer 1 did not count");
  a_mode13_wrap: assert property (@(posedge clk) disable iff (reset)
    (cfg[0].mode == `MODE_13BIT && inc_lo[0] && !wr
     && {high_reg[0], low_reg[0][4:0]} == 13'h1FFF)
    |=> (high_reg[0] == 8'h00 && low_reg[0][4:0] == 5'h00 && timer0_overflow_flag))
    else $error("13-bit wrap wrong");
  a_reload_value: assert property (@(posedge clk) disable iff (reset)
    (cfg[0].mode == `MODE_RELOAD && inc_lo[0] && !wr && low_reg[0] == 8'hFF)
    |=> (low_reg[0] == $past(high_reg[0]) && high_reg[0] == $past(high_reg[0])))
    else $error("reload from high byte wrong");
  a_ext0_edge_flag: assert property (@(posedge clk) disable iff (reset)
    (timer_control_reg[`TC_EXT0_TYPE] && act[0] && !act_d_reg[0])
    |=> ext_irq0_flag) else $error("input 0 edge missed");
  a_ack_one_cycle: assert property (@(posedge clk) disable iff (reset)
    ack_o |=> !ack_o) else $error("ack held over two cycles");

  // Flag, hold and count checks; a clear in the same cycle as a set is left out
  a_tf1_vector_clear: assert property (@(posedge clk) disable iff (reset)
    (timer1_vector && !set_tf1 && !(wr && hit(idx, `IDX_TIMER_CONTROL)))
    |=> !timer1_overflow_flag) else $error("vector did not clear timer 1 flag");
  a_t1_stopped_hold: assert property (@(posedge clk) disable iff (reset)
    (!split0 && !timer_control_reg[`TC_TIMER1_RUN] && !(wr && hit(idx, `IDX_TIMER1_LOW)))
    |=> low_reg[1] == $past(low_reg[1])) else $error("stopped timer 1 moved");
  a_ext1_edge_flag: assert property (@(posedge clk) disable iff (reset)
    (timer_control_reg[`TC_EXT1_TYPE] && act[1] && !act_d_reg[1])
    |=> ext_irq1_flag) else $error("input 1 edge missed");
  a_ext0_level_flag: assert property (@(posedge clk) disable iff (reset)
    (!timer_control_reg[`TC_EXT0_TYPE] && act[0])
    |=> ext_irq0_flag) else $error("input 0 level missed");
  a_ext1_level_flag: assert property (@(posedge clk) disable iff (reset)
    (!timer_control_reg[`TC_EXT1_TYPE] && act[1])
    |=> ext_irq1_flag) else $error("input 1 level missed");
  a_ext0_level_keep: assert property (@(posedge clk) disable iff (reset)
    (ext_irq0_vector && !timer_control_reg[`TC_EXT0_TYPE] && ext_irq0_flag
     && !(wr && hit(idx, `IDX_TIMER_CONTROL))) |=> ext_irq0_flag) else $error("level flag lost");
  a_t0_pin_count: assert property (@(posedge clk) disable iff (reset)
    (cfg[0].mode == `MODE_16BIT && cfg[0].csel && run[0] && fall[0] && !wr)
    |=> low_reg[0] == $past(low_reg[0]) + 8'h01) else $error("pin fall not counted");
  a_t0_carry_high: assert property (@(posedge clk) disable iff (reset)
    (cfg[0].mode == `MODE_16BIT && inc_lo[0] && !wr && low_reg[0] == 8'hFF)
    |=> high_reg[0] == $past(high_reg[0]) + 8'h01) else $error("16-bit carry lost");
  a_split_high_count: assert property (@(posedge clk) disable iff (reset)
    (split0 && timer_control_reg[`TC_TIMER1_RUN] && !prescale_reg[0] && !wr)
    |=> high_reg[0] == $past(high_reg[0]) + 8'h01) else $error("split high byte idle");
  a_t1_inactive_hold: assert property (@(posedge clk) disable iff (reset)
    (cfg[1].mode == `MODE_SPLIT && !(wr && hit(idx, `IDX_TIMER1_LOW)))
    |=> low_reg[1] == $past(low_reg[1])) else $error("inactive timer 1 moved");
endmodule : dual_timer_control
`default_nettype wire

// File: dual_timer_control_bench.sv
// Self-checking bench for the dual timer registers, counting and flags
`timescale 1ns/100ps
`default_nettype none
`include "timer_defs.svh"
module dual_timer_control_bench;
  logic        clk;
  logic        reset;
  logic [9:0]  adr;
  logic [31:0] wdat;
  logic        we;
  logic [3:0]  sel;
  logic        cyc;
  logic        stb;
  logic [31:0] rdat;
  logic        ack;
  logic [1:0]  ext_in;
  logic [1:0]  pin;
  logic [1:0]  tvec;
  logic [1:0]  evec;
  logic [1:0]  tflag;
  logic [1:0]  eflag;
  logic [7:0]  rv;
  int          errors;
  int          checked;

  // Short prescale keeps the timed waits brief
  dual_timer_control #(.PRESCALE(2)) dut_u (
    .clk(clk), .reset(reset), .adr_i(adr), .dat_i(wdat), .we_i(we), .sel_i(sel),
    .cyc_i(cyc), .stb_i(stb), .dat_o(rdat), .ack_o(ack),
    .ext_irq0_input(ext_in[0]), .ext_irq1_input(ext_in[1]),
    .timer0_count_pin(pin[0]), .timer1_count_pin(pin[1]),
    .timer0_vector(tvec[0]), .timer1_vector(tvec[1]),
    .ext_irq0_vector(evec[0]), .ext_irq1_vector(evec[1]),
    .timer0_overflow_flag(tflag[0]), .timer1_overflow_flag(tflag[1]),
    .ext_irq0_flag(eflag[0]), .ext_irq1_flag(eflag[1])
  );

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic complete_run;
    $display("Counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One classic cycle; held until ack is sampled, then one idle cycle
  task automatic wb_cycle(input logic [7:0] idx, input logic wr, input logic [15:0] d,
                          input logic [3:0] s);
    int n;
    adr  <= {idx, 2'h0};
    wdat <= {16'h0000, d};
    we   <= wr;
    sel  <= s;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rv = rdat[7:0];
    if (ack !== 1'b1)
    begin
      errors++;
      $display("[ERR] bus ack expected 1 seen %b", ack);
      complete_run();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask : wb_cycle

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb_cycle(idx, 1'b1, {8'h00, d}, 4'h1);
  endtask : wr

  // Masked control write: only bits set in mask take the data
  task automatic ctl(input logic [7:0] mask, input logic [7:0] d);
    wb_cycle(`IDX_TIMER_CONTROL, 1'b1, {mask, d}, 4'h3);
  endtask : ctl

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    wb_cycle(idx, 1'b0, 16'h0000, 4'h1);
    check(name, rv, exp);
  endtask : rd_chk

  // Falling edges on a count pin, slow enough for the one-sample edge detect
  task automatic fall(input int k, input int n);
    repeat (n)
    begin
      pin[k] <= 1'b0;
      repeat (4) @(posedge clk);
      pin[k] <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask : fall

  // One-cycle vector pulse; sel_ext picks the external input vectors
  task automatic pulse(input logic sel_ext, input int k);
    if (sel_ext)
      evec[k] <= 1'b1;
    else
      tvec[k] <= 1'b1;
    @(posedge clk);
    evec <= 2'h0;
    tvec <= 2'h0;
    repeat (2) @(posedge clk);
  endtask : pulse

  task automatic wait_ovf(input int k);
    int n;
    n = 0;
    while (tflag[k] !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    check("overflow wait", {7'h00, tflag[k]}, 8'h01);
    if (tflag[k] !== 1'b1)
      complete_run();
  endtask : wait_ovf

  // Main sequence; external inputs idle high since polarity resets to active low
  initial
  begin
    logic [7:0] idx_tab [5];
    idx_tab = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C};
    clk = 1'b0; reset = 1'b1; adr = '0; wdat = '0; we = 1'b0; sel = '0;
    cyc = 1'b0; stb = 1'b0; ext_in = 2'h3; pin = 2'h3; tvec = '0; evec = '0;
    errors = 0; checked = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("flags after reset", {4'h0, tflag, eflag}, 8'h00);
    foreach (idx_tab[i]) rd_chk("reset value", idx_tab[i], `RESET_BYTE);
    // Plain read/write, refused lane, unmapped index
    wr(`IDX_TIMER0_LOW, 8'h5A); wr(`IDX_TIMER0_HIGH, 8'hA5); wr(`IDX_TIMER1_LOW, 8'h3C);
    rd_chk("t0 low", `IDX_TIMER0_LOW, 8'h5A);
    rd_chk("t0 high", `IDX_TIMER0_HIGH, 8'hA5);
    rd_chk("t1 low", `IDX_TIMER1_LOW, 8'h3C);
    wb_cycle(`IDX_TIMER0_LOW, 1'b1, 16'h0000, 4'h0);
    rd_chk("lane off write", `IDX_TIMER0_LOW, 8'h5A);
    wr(8'h90, 8'hFF);
    rd_chk("unmapped", 8'h90, 8'h00);
    ctl(8'h04, 8'hFF);
    rd_chk("single bit set", `IDX_TIMER_CONTROL, 8'h04);
    ctl(8'h04, 8'h00);
    rd_chk("single bit clear", `IDX_TIMER_CONTROL, 8'h00);
    // Timer 0 as 13-bit pin counter across the wrap
    wr(`IDX_TIMER_MODE, 8'h04); wr(`IDX_TIMER0_HIGH, 8'hFF); wr(`IDX_TIMER0_LOW, 8'h1D);
    ctl(8'h10, 8'h10);
    rd_chk("count kept at run", `IDX_TIMER0_LOW, 8'h1D);
    fall(0, 2);
    rd_chk("t0 pin count", `IDX_TIMER0_LOW, 8'h1F);
    check("t0 flag early", {7'h00, tflag[0]}, 8'h00);
    fall(0, 1);
    rd_chk("13-bit wrap high", `IDX_TIMER0_HIGH, 8'h00);
    rd_chk("13-bit wrap low", `IDX_TIMER0_LOW, 8'h00);
    check("t0 flag set", {7'h00, tflag[0]}, 8'h01);
    pulse(1'b0, 0);
    check("t0 vector clear", {7'h00, tflag[0]}, 8'h00);
    ctl(8'h10, 8'h00);
    fall(0, 1);
    rd_chk("t0 stopped", `IDX_TIMER0_LOW, 8'h00);
    // Gate: counts only while input 0 is active (low)
    wr(`IDX_TIMER_MODE, 8'h0D);
    ctl(8'h10, 8'h10);
    fall(0, 1);
    rd_chk("gate closed", `IDX_TIMER0_LOW, 8'h00);
    ext_in[0] <= 1'b0;
    fall(0, 1);
    rd_chk("gate open", `IDX_TIMER0_LOW, 8'h01);
    ext_in[0] <= 1'b1;
    repeat (3) @(posedge clk);
    ctl(8'h12, 8'h00);
    // Timer 1 as 8-bit reload pin counter, then inactive mode
    wr(`IDX_TIMER_MODE, 8'h60); wr(`IDX_TIMER1_HIGH, 8'hA0); wr(`IDX_TIMER1_LOW, 8'hFE);
    ctl(8'h40, 8'h40);
    fall(1, 2);
    rd_chk("reloaded low", `IDX_TIMER1_LOW, 8'hA0);
    rd_chk("reload kept", `IDX_TIMER1_HIGH, 8'hA0);
    check("t1 flag set", {7'h00, tflag[1]}, 8'h01);
    ctl(8'h80, 8'h00);
    check("t1 soft clear", {7'h00, tflag[1]}, 8'h00);
    wr(`IDX_TIMER_MODE, 8'h70);
    fall(1, 1);
    rd_chk("t1 inactive", `IDX_TIMER1_LOW, 8'hA0);
    ctl(8'h40, 8'h00);
    // External flags: edge then level for each input
    for (int k = 0; k < 2; k++)
    begin
      ctl(8'h01 << (2 * k), 8'hFF);
      ext_in[k] <= 1'b0;
      repeat (4) @(posedge clk);
      check("edge flag", {7'h00, eflag[k]}, 8'h01);
      pulse(1'b1, k);
      check("edge vector clear", {7'h00, eflag[k]}, 8'h00);
      ext_in[k] <= 1'b1;
      repeat (3) @(posedge clk);
      ctl(8'h01 << (2 * k), 8'h00);
      ext_in[k] <= 1'b0;
      repeat (4) @(posedge clk);
      pulse(1'b1, k);
      check("level flag held", {7'h00, eflag[k]}, 8'h01);
      ext_in[k] <= 1'b1;
      repeat (3) @(posedge clk);
      ctl(8'h02 << (2 * k), 8'h00);
      check("level soft clear", {7'h00, eflag[k]}, 8'h00);
    end
    // Timer 0 16-bit on the prescaled clock
    wr(`IDX_PRESCALE_CTRL, 8'h01); wr(`IDX_TIMER_MODE, 8'h01);
    wr(`IDX_TIMER0_LOW, 8'hF0); wr(`IDX_TIMER0_HIGH, 8'hFF);
    ctl(8'h10, 8'h10);
    wait_ovf(0);
    ctl(8'h30, 8'h00);
    // Timer 0 8-bit reload on the prescaled tick, timer 1 16-bit on every clock
    wr(`IDX_TIMER_MODE, 8'h12);
    wr(`IDX_TIMER0_HIGH, 8'h80);
    wr(`IDX_TIMER0_LOW, 8'hF8);
    ctl(8'h10, 8'h10);
    wait_ovf(0);
    rd_chk("t0 reload kept", `IDX_TIMER0_HIGH, 8'h80);
    ctl(8'h30, 8'h00);
    wr(`IDX_TIMER1_LOW, 8'hF0);
    wr(`IDX_TIMER1_HIGH, 8'hFF);
    ctl(8'h40, 8'h40);
    wait_ovf(1);
    pulse(1'b0, 1);
    check("t1 vector clear", {7'h00, tflag[1]}, 8'h00);
    ctl(8'h40, 8'h00);
    // Split mode: high byte run by timer 1 bit, sets timer 1 flag
    wr(`IDX_PRESCALE_CTRL, 8'h00); wr(`IDX_TIMER_MODE, 8'h03);
    wr(`IDX_TIMER0_LOW, 8'h33); wr(`IDX_TIMER0_HIGH, 8'hF0);
    ctl(8'h40, 8'h40);
    wait_ovf(1);
    rd_chk("split low idle", `IDX_TIMER0_LOW, 8'h33);
    ctl(8'hC0, 8'h00);
    complete_run();
  end
endmodule : dual_timer_control_bench
`default_nettype wire
